// File: verilog/cpld_macrocell_array.sv
// The 32-macrocell logic array with switch matrix, foldback and keepers.
// Assumes board pins synchronous to CORE_CLK; configuration loads by port.
`default_nettype none
`include "cpld_cfg.svh"

// Contract
// - Five product terms over global and regional buses.
// - Selector assigns each term to sum or control.
// - OR sums five terms, cascade extends to forty.
// - Four cascade chains of forty-term fan-in.
// - XOR takes term or constant for polarity.
// - XOR feedback gives toggle and JK modes.
// - Data from XOR, separate term or pin.
// - Latch mode transparent while clock high.
// - Clock from three globals or term, rising.
// - Low clock enable ignores global clock edges; latch mode still loads while the clock is high.
// - Clear: global, term, both ORed, or off.
// - Preset: product term or off.
// - Output and feedback independently registered or combinatorial.
// - Output enable from pins, I/O or macrocells.
// - Input-configured I/O keeps full macrocell use.
// - Global bus feeds forty-signal switch matrices.
// - Inverted foldback term shared by four macrocells.
// - Dedicated inputs usable as global controls.
// - Keeper holds last level of floating pin.
// - Signature readable despite security fuse.
module cpld_macrocell_array (
    // Clock and reset.
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST_N,
    // Board pins.
    input  wire logic [3:0]            DIN,
    input  wire logic [31:0]           IO_IN,
    input  wire logic [31:0]           IO_EXT_DRV,
    output logic      [31:0]           IO_OUT,
    output logic      [31:0]           IO_OE,
    // Options.
    input  wire logic                  KEEPER_EN,
    // Configuration port.
    input  wire logic                  CFG_WE,
    input  wire logic                  CFG_RD,
    input  wire logic [1:0]            CFG_SPACE,
    input  wire logic [4:0]            CFG_MC,
    input  wire logic [5:0]            CFG_WORD,
    input  wire logic [`CFG_W-1:0]     CFG_WDATA,
    output logic      [`CFG_W-1:0]     CFG_RDATA,
    output logic                       SECURE
);

    ////////////////////////////////////////////////////////////////////////
    // Storage.
    logic [`CFG_W-1:0]      tmask_r  [0:`MC_COUNT-1][0:`PT_COUNT-1];
    logic [`CFG_W-1:0]      cmask_r  [0:`MC_COUNT-1][0:`PT_COUNT-1];
    logic [`CFG_W-1:0]      ctrl_r   [0:`MC_COUNT-1];
    logic [`CFG_W-1:0]      route_r  [0:`MC_COUNT-1];
    logic [6:0]             sm_sel_r [0:1][0:`SM_COUNT-1];
    logic [`SIG_W-1:0]      sig_r;
    logic [`GBUS_COUNT-1:0] gbus_r;
    logic [`MC_COUNT-1:0]   fold_r;
    logic [`MC_COUNT-1:0]   q_r;
    logic [`MC_COUNT-1:0]   clk_prev_r;
    logic [31:0]            keep_r;

    logic [`SM_COUNT-1:0]   sm      [0:1];
    logic [`PT_COUNT-1:0]   pt      [0:`MC_COUNT-1];
    logic [`MC_COUNT-1:0]   sum;
    logic [`MC_COUNT-1:0]   xo;
    logic [`MC_COUNT-1:0]   d;
    logic [`MC_COUNT-1:0]   mclk;
    logic [`MC_COUNT-1:0]   ce;
    logic [`MC_COUNT-1:0]   clr;
    logic [`MC_COUNT-1:0]   pre;
    logic [`MC_COUNT-1:0]   latch;
    logic [`MC_COUNT-1:0]   out_nxt;
    logic [`MC_COUNT-1:0]   fb;
    logic [`MC_COUNT-1:0]   oe_nxt;
    logic [`MC_COUNT-1:0]   fold_nxt;
    logic [31:0]            pin_lvl;

    ////////////////////////////////////////////////////////////////////////
    // Product term: true and complement masks over the switch matrix,
    // plus a mask over the four regional foldback terms.
    function automatic logic pt_eval(
        input logic [`SM_COUNT-1:0] s,
        input logic [`CFG_W-1:0]    tm,
        input logic [`CFG_W-1:0]    cm,
        input logic [3:0]           rm,
        input logic [3:0]           rg
    );
        pt_eval = &((~tm | s) & (~cm | ~s)) & &(~rm | rg);
    endfunction : pt_eval

    // OR of the product terms of one macrocell that hold a given role.
    function automatic logic role_or(
        input logic [`PT_COUNT-1:0] p,
        input logic [`CFG_W-1:0]    rt,
        input cpld_pkg::pt_role_type role
    );
        role_or = 1'b0;
        for (int k = 0; k < `PT_COUNT; k++) begin
            if (rt[`ROUTE_ROLE + 3 * k +: 3] == role) begin
                role_or = role_or | p[k];
            end
        end
    endfunction : role_or

    ////////////////////////////////////////////////////////////////////////
    // Pin level seen by the array, with the keeper on floating pins.
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (IO_OE[i]) begin
                pin_lvl[i] = IO_OUT[i];
            end else if (IO_EXT_DRV[i] || !KEEPER_EN) begin
                pin_lvl[i] = IO_IN[i];
            end else begin
                pin_lvl[i] = keep_r[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Macrocell logic.
    always_comb begin
        logic [`CFG_W-1:0] c;
        logic              xpt;
        logic [1:0]        cs;
        logic [4:0]        ix;
        logic [2:0]        fs;
        c = '0;
        xpt = 1'b0;
        cs = 2'h0;
        ix = 5'h00;
        fs = 3'h0;
        for (int b = 0; b < 2; b++) begin
            for (int s = 0; s < `SM_COUNT; s++) begin
                sm[b][s] = (sm_sel_r[b][s] < 7'(`GBUS_COUNT)) ?
                           gbus_r[sm_sel_r[b][s]] : 1'b0;
            end
        end
        for (int m = 0; m < `MC_COUNT; m++) begin
            c = ctrl_r[m];
            for (int k = 0; k < `PT_COUNT; k++) begin
                pt[m][k] = pt_eval(sm[m / `BLOCK_SIZE], tmask_r[m][k],
                    cmask_r[m][k], route_r[m][`ROUTE_RMASK + 4 * k +: 4],
                    fold_r[(m / `REGION_SIZE) * `REGION_SIZE +: 4]);
            end
            sum[m] = role_or(pt[m], route_r[m], cpld_pkg::ROLE_SUM);
            if (c[`CTRL_CASC_EN] && (m % `CHAIN_LEN) != 0) begin
                sum[m] = sum[m] | sum[m - 1];
            end
            xpt = role_or(pt[m], route_r[m], cpld_pkg::ROLE_XOR);
            case (c[`CTRL_XOR_SEL +: 2])
                2'h1:    xo[m] = ~sum[m];
                2'h2:    xo[m] = sum[m] ^ xpt;
                default: xo[m] = sum[m];
            endcase
            case (c[`CTRL_DSEL +: 2])
                2'h1:    d[m] = role_or(pt[m], route_r[m],
                                        cpld_pkg::ROLE_DSEP);
                2'h2:    d[m] = pin_lvl[m];
                default: d[m] = xo[m];
            endcase
            latch[m] = 1'b0;
            case (cpld_pkg::ff_mode_type'(c[`CTRL_MODE +: 3]))
                cpld_pkg::MODE_T:     d[m] = xo[m] ^ q_r[m];
                cpld_pkg::MODE_JK:    d[m] = (sum[m] & ~q_r[m]) |
                                             (~xpt & q_r[m]);
                cpld_pkg::MODE_SR:    d[m] = sum[m] | (~xpt & q_r[m]);
                cpld_pkg::MODE_LATCH: latch[m] = 1'b1;
                default:              latch[m] = 1'b0;
            endcase
            cs = c[`CTRL_CLK_SEL +: 2];
            mclk[m] = (cs == 2'h3) ?
                role_or(pt[m], route_r[m], cpld_pkg::ROLE_CLK) :
                DIN[cs];
            ce[m] = (cs != 2'h3 && c[`CTRL_CE_EN]) ?
                role_or(pt[m], route_r[m], cpld_pkg::ROLE_CE) : 1'b1;
            case (c[`CTRL_CLR_SEL +: 2])
                2'h1:    clr[m] = DIN[3];
                2'h2:    clr[m] = role_or(pt[m], route_r[m],
                                          cpld_pkg::ROLE_CLR);
                2'h3:    clr[m] = DIN[3] | role_or(pt[m], route_r[m],
                                          cpld_pkg::ROLE_CLR);
                default: clr[m] = 1'b0;
            endcase
            pre[m] = c[`CTRL_PRE_EN] &
                role_or(pt[m], route_r[m], cpld_pkg::ROLE_PRE);
            out_nxt[m] = c[`CTRL_OUT_REG] ? q_r[m] : xo[m];
            fb[m] = c[`CTRL_FB_REG] ? q_r[m] : xo[m];
            fs = c[`CTRL_FOLD_SEL +: 3];
            fold_nxt[m] = (fs < 3'(`PT_COUNT)) ? ~pt[m][fs] : 1'b1;
        end
        // Enables read the feedback of any macrocell, so all are done first.
        for (int m = 0; m < `MC_COUNT; m++) begin
            c = ctrl_r[m];
            ix = c[`CTRL_OE_IDX +: 5];
            case (cpld_pkg::oe_sel_type'(c[`CTRL_OE_SEL +: 3]))
                cpld_pkg::OE_PIN0:   oe_nxt[m] = DIN[0];
                cpld_pkg::OE_PIN0_N: oe_nxt[m] = ~DIN[0];
                cpld_pkg::OE_PIN1:   oe_nxt[m] = DIN[1];
                cpld_pkg::OE_PIN1_N: oe_nxt[m] = ~DIN[1];
                cpld_pkg::OE_IO:     oe_nxt[m] = pin_lvl[ix];
                cpld_pkg::OE_MC:     oe_nxt[m] = fb[ix];
                cpld_pkg::OE_ALWAYS: oe_nxt[m] = 1'b1;
                default:             oe_nxt[m] = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage elements.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q_r <= '0;
            clk_prev_r <= '0;
        end else begin
            clk_prev_r <= mclk;
            for (int m = 0; m < `MC_COUNT; m++) begin
                if (clr[m]) begin
                    q_r[m] <= 1'b0;
                end else if (pre[m]) begin
                    q_r[m] <= 1'b1;
                end else if (latch[m]) begin
                    if (mclk[m]) begin
                        q_r[m] <= d[m];
                    end
                end else if (mclk[m] && !clk_prev_r[m] && ce[m]) begin
                    q_r[m] <= d[m];
                end
            end
        end
    end

    // Buses, pins and keepers.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            gbus_r <= '0;
            fold_r <= '1;
            IO_OUT <= '0;
            IO_OE <= '0;
            keep_r <= '0;
        end else begin
            gbus_r <= {fb, DIN, pin_lvl};
            fold_r <= fold_nxt;
            IO_OUT <= out_nxt;
            IO_OE <= oe_nxt;
            keep_r <= pin_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration load and readback.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int m = 0; m < `MC_COUNT; m++) begin
                for (int k = 0; k < `PT_COUNT; k++) begin
                    tmask_r[m][k] <= `CFG_RESET;
                    cmask_r[m][k] <= `CFG_RESET;
                end
                ctrl_r[m] <= `CFG_RESET;
                route_r[m] <= `CFG_RESET;
            end
            for (int b = 0; b < 2; b++) begin
                for (int s = 0; s < `SM_COUNT; s++) begin
                    sm_sel_r[b][s] <= 7'h7f;
                end
            end
        end else if (CFG_WE && CFG_SPACE == `SPACE_MC) begin
            if (CFG_WORD < `WORD_CMASK0) begin
                tmask_r[CFG_MC][CFG_WORD[2:0]] <= CFG_WDATA;
            end else if (CFG_WORD < `WORD_CTRL) begin
                cmask_r[CFG_MC][3'(CFG_WORD - `WORD_CMASK0)] <= CFG_WDATA;
            end else if (CFG_WORD == `WORD_CTRL) begin
                ctrl_r[CFG_MC] <= CFG_WDATA;
            end else if (CFG_WORD == `WORD_ROUTE) begin
                route_r[CFG_MC] <= CFG_WDATA;
            end
        end else if (CFG_WE && CFG_SPACE == `SPACE_SM &&
                     CFG_WORD < 6'(`SM_COUNT)) begin
            sm_sel_r[CFG_MC[0]][CFG_WORD] <= CFG_WDATA[6:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sig_r <= `SIG_RESET;
            SECURE <= 1'b0;
        end else if (CFG_WE && CFG_SPACE == `SPACE_SEC) begin
            if (CFG_WORD == `WORD_SIG) begin
                sig_r <= CFG_WDATA[`SIG_W-1:0];
            end else if (CFG_WORD == `WORD_FUSE && CFG_WDATA[0]) begin
                SECURE <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            CFG_RDATA <= '0;
        end else if (!CFG_RD) begin
            CFG_RDATA <= CFG_RDATA;
        end else if (CFG_SPACE == `SPACE_SEC) begin
            if (CFG_WORD == `WORD_SIG) begin
                CFG_RDATA <= {24'h00_0000, sig_r};
            end else if (CFG_WORD == `WORD_FUSE) begin
                CFG_RDATA <= {39'h0, SECURE};
            end else begin
                CFG_RDATA <= '0;
            end
        end else if (SECURE) begin
            CFG_RDATA <= '0;
        end else if (CFG_SPACE == `SPACE_MC) begin
            if (CFG_WORD < `WORD_CMASK0) begin
                CFG_RDATA <= tmask_r[CFG_MC][CFG_WORD[2:0]];
            end else if (CFG_WORD < `WORD_CTRL) begin
                CFG_RDATA <= cmask_r[CFG_MC][3'(CFG_WORD - `WORD_CMASK0)];
            end else if (CFG_WORD == `WORD_CTRL) begin
                CFG_RDATA <= ctrl_r[CFG_MC];
            end else if (CFG_WORD == `WORD_ROUTE) begin
                CFG_RDATA <= route_r[CFG_MC];
            end else begin
                CFG_RDATA <= '0;
            end
        end else if (CFG_SPACE == `SPACE_SM && CFG_WORD < 6'(`SM_COUNT)) begin
            CFG_RDATA <= {33'h0, sm_sel_r[CFG_MC[0]][CFG_WORD]};
        end else begin
            CFG_RDATA <= '0;
        end
    end

endmodule : cpld_macrocell_array
`default_nettype wire

// File: verilog/cpld_cfg.svh
// Constants for the macrocell array: sizes, configuration map, fields.
// Assumes inclusion by bare name from the package and the array module.
`ifndef CPLD_CFG_SVH
`define CPLD_CFG_SVH

// Array sizes.
`define MC_COUNT        32
`define DIN_COUNT       4
`define SM_COUNT        40
`define GBUS_COUNT      68
`define PT_COUNT        5
`define REGION_SIZE     4
`define CHAIN_LEN       8
`define BLOCK_SIZE      16
`define CFG_W           40
`define SIG_W           16

// Global bus layout: pins, then dedicated inputs, then feedback.
`define GBUS_PIN_BASE   0
`define GBUS_DIN_BASE   32
`define GBUS_FB_BASE    36

// Configuration spaces and words.
`define SPACE_MC        2'h0
`define SPACE_SM        2'h1
`define SPACE_SEC       2'h2
`define WORD_TMASK0     6'h00
`define WORD_CMASK0     6'h05
`define WORD_CTRL       6'h0a
`define WORD_ROUTE      6'h0b
`define WORD_SIG        6'h00
`define WORD_FUSE       6'h01

// Control word fields.
`define CTRL_XOR_SEL    0
`define CTRL_MODE       2
`define CTRL_DSEL       5
`define CTRL_CLK_SEL    7
`define CTRL_CE_EN      9
`define CTRL_CLR_SEL    10
`define CTRL_PRE_EN     12
`define CTRL_OUT_REG    13
`define CTRL_FB_REG     14
`define CTRL_OE_SEL     15
`define CTRL_OE_IDX     18
`define CTRL_CASC_EN    23
`define CTRL_FOLD_SEL   24

// Route word fields: regional masks at 4*k, roles at 20+3*k.
`define ROUTE_RMASK     0
`define ROUTE_ROLE      20

// Reset values.
`define SIG_RESET       16'h0000
`define CFG_RESET       40'h00_0000_0000
`endif

// File: verilog/cpld_pkg.sv
// Types for the macrocell array.
// Assumes cpld_cfg.svh is on the include path.
`default_nettype none
`include "cpld_cfg.svh"
package cpld_pkg;
    typedef enum logic [2:0] {
        ROLE_SUM, ROLE_XOR, ROLE_CLK, ROLE_CE, ROLE_CLR, ROLE_PRE, ROLE_DSEP,
        ROLE_OFF
    } pt_role_type;
    typedef enum logic [2:0] {
        MODE_D, MODE_T, MODE_JK, MODE_SR, MODE_LATCH
    } ff_mode_type;
    typedef enum logic [2:0] {
        OE_PIN0, OE_PIN0_N, OE_PIN1, OE_PIN1_N, OE_IO, OE_MC, OE_NEVER,
        OE_ALWAYS
    } oe_sel_type;
endpackage : cpld_pkg
`default_nettype wire

// File: verif/board_model.sv
// Board model: drives the dedicated inputs and the I/O pin levels.
// Assumes the bench sets wanted levels and drive enables at clock edges.
`default_nettype none
module board_model (
    // Wanted levels from the bench.
    input  wire logic [3:0]  din_set,
    input  wire logic [31:0] pin_val,
    input  wire logic [31:0] pin_drv,
    // Device side.
    input  wire logic [31:0] io_out,
    input  wire logic [31:0] io_oe,
    output logic      [3:0]  din,
    output logic      [31:0] io_in,
    output logic      [31:0] ext_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////
    assign din = din_set;
    assign ext_drv = pin_drv;
    // A pin nobody drives shows the inverse of the wanted level.
    assign io_in = (pin_drv & pin_val) | (~pin_drv & io_oe & io_out)
                 | (~pin_drv & ~io_oe & ~pin_val);
endmodule : board_model
`default_nettype wire

// File: verif/cpld_array_chk.sv
// Checker for the configuration port, fuse and reset state.
// Assumes it is bound to the array top and sees only its ports.
`default_nettype none
module cpld_array_chk (
    // Clock and reset.
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    // Configuration port and pins.
    input wire logic        CFG_WE,
    input wire logic        CFG_RD,
    input wire logic [1:0]  CFG_SPACE,
    input wire logic [5:0]  CFG_WORD,
    input wire logic [39:0] CFG_WDATA,
    input wire logic [39:0] CFG_RDATA,
    input wire logic        SECURE,
    input wire logic [31:0] IO_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sig_r;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////
    // Shadow of the signature word.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sig_r <= 16'h0000;
        end else if (CFG_WE && CFG_SPACE == 2'h2 && CFG_WORD == 6'h00) begin
            sig_r <= CFG_WDATA[15:0];
        end
    end
    ////////////////////////////////
    sequence s_sig_rd;
        CFG_RD && CFG_SPACE == 2'h2 && CFG_WORD == 6'h00;
    endsequence
    sequence s_fuse_wr;
        CFG_WE && CFG_SPACE == 2'h2 && CFG_WORD == 6'h01;
    endsequence
    property p_sig_read;
        s_sig_rd |=> CFG_RDATA == {24'h000000, $past(sig_r)};
    endproperty
    property p_rst_quiet;
        $rose(RST_N) |-> IO_OE == 32'h0 && !SECURE && CFG_RDATA == 40'h0;
    endproperty
    property p_rd_hold;
        !CFG_RD |=> $stable(CFG_RDATA);
    endproperty
    property p_sec_sticky;
        SECURE |=> SECURE;
    endproperty
    property p_sec_set;
        s_fuse_wr ##0 CFG_WDATA[0] |=> SECURE;
    endproperty
    property p_sec_keep0;
        s_fuse_wr ##0 (!CFG_WDATA[0] && !SECURE) |=> !SECURE;
    endproperty
    property p_sec_hide;
        SECURE && CFG_RD && CFG_SPACE < 2'h2 |=> CFG_RDATA == 40'h0;
    endproperty
    property p_unmapped;
        CFG_RD && CFG_SPACE == 2'h2 && CFG_WORD > 6'h01 |=> CFG_RDATA == 40'h0;
    endproperty
    a_sig_read: assert property (p_sig_read)
        else $error("signature read wrong");
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs not quiet after reset");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");
    a_sec_sticky: assert property (p_sec_sticky)
        else $error("fuse cleared without reset");
    a_sec_set: assert property (p_sec_set)
        else $error("fuse not set");
    a_sec_keep0: assert property (p_sec_keep0)
        else $error("fuse set by a zero bit");
    a_sec_hide: assert property (p_sec_hide)
        else $error("secured configuration visible");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped word not zero");
endmodule : cpld_array_chk
`default_nettype wire

// File: verif/cpld_macrocell_array_tb_top.sv
// Bench for the macrocell array: config tasks and pin scenarios.
// Assumes the design, board model and checker are compiled first.
`default_nettype none
module cpld_macrocell_array_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk  = 1'b0;
    logic        rst_n     = 1'b0;
    logic        keeper_en = 1'b0;
    logic [3:0]  din_set   = 4'h0;
    logic [31:0] pin_val   = 32'h0;
    logic [31:0] pin_drv   = 32'h0;
    logic        cfg_we    = 1'b0;
    logic        cfg_rd    = 1'b0;
    logic [1:0]  cfg_space = 2'h0;
    logic [5:0]  cfg_word  = 6'h00;
    logic [39:0] cfg_wdata = 40'h0;
    logic [3:0]  din;
    logic [31:0] io_in, ext_drv, io_out, io_oe;
    logic [39:0] cfg_rdata;
    logic        secure;
    int          err_total   = 0;
    int          check_count = 0;
    int          cycles      = 0;
    ////////////////////////////////
    always #5 core_clk = ~core_clk;
    board_model board (.din_set(din_set), .pin_val(pin_val),
        .pin_drv(pin_drv), .io_out(io_out), .io_oe(io_oe), .din(din),
        .io_in(io_in), .ext_drv(ext_drv));
    cpld_macrocell_array uut (.CORE_CLK(core_clk), .RST_N(rst_n),
        .DIN(din), .IO_IN(io_in), .IO_EXT_DRV(ext_drv), .IO_OUT(io_out),
        .IO_OE(io_oe), .KEEPER_EN(keeper_en), .CFG_WE(cfg_we),
        .CFG_RD(cfg_rd), .CFG_SPACE(cfg_space), .CFG_MC(5'h00),
        .CFG_WORD(cfg_word), .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata),
        .SECURE(secure));
    ////////////////////////////////
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    task automatic put(input logic [1:0] sp, input logic [5:0] wd,
                       input logic [39:0] d);
        @(posedge core_clk);
        cfg_space <= sp;
        cfg_word <= wd;
        cfg_wdata <= d;
    endtask : put
    task automatic wr(input logic [1:0] sp, input logic [5:0] wd,
                      input logic [39:0] d);
        put(sp, wd, d);
        cfg_we <= 1'b1;
        @(posedge core_clk);
        cfg_we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] sp, input logic [5:0] wd,
                      input logic [39:0] exp);
        put(sp, wd, 40'h0);
        cfg_rd <= 1'b1;
        @(posedge core_clk);
        cfg_rd <= 1'b0;
        #1 chk(cfg_rdata, exp);
    endtask : rd
    // Sets dedicated inputs and pin 5, waits, checks macrocell 0 output.
    task automatic pins(input logic [3:0] d, input logic v,
                        input logic dr, input logic e);
        @(posedge core_clk);
        din_set <= d;
        pin_val[5] <= v;
        pin_drv[5] <= dr;
        repeat (4) @(posedge core_clk);
        #1 chk({39'h0, io_out[0]}, {39'h0, e});
    endtask : pins
    ////////////////////////////////
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        keeper_en <= 1'b1;
        #1 chk({8'h0, io_oe}, 40'h0);
        rd(2'h2, 6'h00, 40'h0);
        wr(2'h2, 6'h00, 40'h00_0000_a5c3);
        rd(2'h2, 6'h00, 40'h00_0000_a5c3);
        rd(2'h2, 6'h07, 40'h0);
        $display("test config done");
        wr(2'h1, 6'h00, 40'h5);
        wr(2'h1, 6'h01, 40'h21);
        wr(2'h0, 6'h00, 40'h1);
        wr(2'h0, 6'h0b, 40'h07_ff80_0000);
        wr(2'h0, 6'h0a, 40'h03_8000);
        rd(2'h0, 6'h0a, 40'h03_8000);
        pins(4'h0, 1'b1, 1'b1, 1'b1);
        chk({8'h0, io_oe}, 40'h1);
        pins(4'h0, 1'b0, 1'b1, 1'b0);
        wr(2'h0, 6'h0a, 40'h03_8001);
        pins(4'h0, 1'b0, 1'b1, 1'b1);
        pins(4'h0, 1'b0, 1'b0, 1'b1);
        $display("test sum done");
        wr(2'h0, 6'h01, 40'h2);
        wr(2'h0, 6'h0b, 40'h07_fd80_0000);
        wr(2'h0, 6'h0a, 40'h03_a700);
        pins(4'h0, 1'b1, 1'b1, 1'b0);
        pins(4'h4, 1'b1, 1'b1, 1'b0);
        pins(4'h2, 1'b1, 1'b1, 1'b0);
        pins(4'h6, 1'b1, 1'b1, 1'b1);
        pins(4'ha, 1'b1, 1'b1, 1'b0);
        pins(4'h2, 1'b1, 1'b1, 1'b0);
        $display("test storage done");
        wr(2'h0, 6'h0b, 40'h07_f580_0000);
        wr(2'h0, 6'h0a, 40'h03_b700);
        pins(4'h2, 1'b1, 1'b1, 1'b1);
        pins(4'ha, 1'b1, 1'b1, 1'b0);
        wr(2'h0, 6'h0a, 40'h03_a710);
        pins(4'h4, 1'b1, 1'b1, 1'b1);
        pins(4'h4, 1'b0, 1'b1, 1'b0);
        pins(4'h0, 1'b1, 1'b1, 1'b0);
        wr(2'h0, 6'h0a, 40'h03_a704);
        pins(4'h2, 1'b1, 1'b1, 1'b0);
        pins(4'h6, 1'b1, 1'b1, 1'b1);
        pins(4'h2, 1'b1, 1'b1, 1'b1);
        pins(4'h6, 1'b1, 1'b1, 1'b0);
        $display("test modes done");
        wr(2'h2, 6'h01, 40'h0);
        #1 chk({39'h0, secure}, 40'h0);
        wr(2'h2, 6'h01, 40'h1);
        #1 chk({39'h0, secure}, 40'h1);
        rd(2'h0, 6'h0a, 40'h0);
        rd(2'h2, 6'h00, 40'h00_0000_a5c3);
        rd(2'h2, 6'h07, 40'h0);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        #1 chk({39'h0, secure}, 40'h0);
        $display("test fuse done");
        results();
    end
endmodule : cpld_macrocell_array_tb_top
bind cpld_macrocell_array cpld_array_chk chk_i (.CORE_CLK, .RST_N,
    .CFG_WE, .CFG_RD, .CFG_SPACE, .CFG_WORD, .CFG_WDATA, .CFG_RDATA,
    .SECURE, .IO_OE);
`default_nettype wire
